/* File: core/srw_pkg.sv */
// constants for the system reset, watchdog and wakeup block
`default_nettype none
package srw_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned RST_HOLD_NS   = 100;
  localparam int unsigned RST_HOLD_CYC  = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [13:0] RESET_PC      = 14'h3ffd;
  localparam logic [8:0]  WDG_SHORT     = 9'h020;
  localparam logic [8:0]  WDG_LONG      = 9'h100;
  // byte offsets on the register bus
  localparam logic [7:0] OFS_CAUSE   = 8'h00;
  localparam logic [7:0] OFS_OPTIONS = 8'h04;
  localparam logic [7:0] OFS_PMC     = 8'h08;
  localparam logic [7:0] OFS_PEND1   = 8'h0c;
  localparam logic [7:0] OFS_PEND2   = 8'h10;
  // reset cause bits
  localparam int unsigned CS_POR = 7;
  localparam int unsigned CS_PIN = 6;
  localparam int unsigned CS_WDG = 5;
  localparam int unsigned CS_OPC = 4;
  localparam int unsigned CS_ADR = 3;
  localparam int unsigned CS_LV  = 1;
  // system options bits
  localparam int unsigned OP_WDG_EN   = 7;
  localparam int unsigned OP_WDG_LONG = 6;
  localparam int unsigned OP_STOP_EN  = 5;
  localparam int unsigned OP_SER_CLK  = 3;
  localparam int unsigned OP_SER_PIN  = 2;
  localparam int unsigned OP_DBG_PIN  = 1;
  localparam int unsigned OP_PIN_RST  = 0;
  localparam logic [7:0]  OPTIONS_RST = 8'hc2;
  localparam logic [7:0]  OPTIONS_FREE = 8'h0c;
  // power mode control bits
  localparam int unsigned PM_LV_FLAG = 7;
  localparam int unsigned PM_LV_ACK  = 6;
  localparam int unsigned PM_LV_IE   = 5;
  localparam int unsigned PM_LV_RE   = 4;
  localparam int unsigned PM_LV_SE   = 3;
  localparam int unsigned PM_LV_EN   = 2;
  localparam logic [7:0]  PMC_RST    = 8'h14;
  localparam logic [7:0]  PMC_RW     = 8'h3c;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  typedef enum logic {SRW_HOLD, SRW_RUN} srw_state_type;
endpackage : srw_pkg
`default_nettype wire

/* File: core/srw_wdg_if.sv */
// carrier between the system block and its watchdog counter
`default_nettype none
interface srw_wdg_if;
  logic tick;
  logic clear;
  logic hold;
  logic stop;
  logic enable;
  logic long_sel;
  logic expire;
  modport ctrl (output tick, clear, hold, stop, enable, long_sel, input expire);
  modport wdg  (input tick, clear, hold, stop, enable, long_sel, output expire);
endinterface : srw_wdg_if
`default_nettype wire

/* File: core/srw_watchdog.sv */
// watchdog counter on the core clock, stepped by the synchronised 1 khz tick
`default_nettype none
module srw_watchdog
  import srw_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  srw_wdg_if.wdg    wdg
);
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       exp_q;
  logic       exp_d;
  logic [8:0] limit;

  always_comb begin
    limit = wdg.long_sel ? WDG_LONG : WDG_SHORT;
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (wdg.clear || wdg.stop || !wdg.enable) begin
      cnt_d = '0;
    end else if (wdg.tick && !wdg.hold) begin
      if (cnt_q == limit - 9'h001) begin
        cnt_d = '0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 9'h001;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign wdg.expire = exp_q;
endmodule : srw_watchdog
`default_nettype wire

/* File: core/srw_top.sv */
// system reset, watchdog, wakeup and low-voltage control with axi4-lite registers
// Contract
// - after reset release, fetch starts at 0x3ffd; control registers take initial values
// - during reset peripherals are disabled and pins are plain high-z inputs
// - seven reset sources; all but debug reset have a cause bit
// - reset pin acts only while the pin reset enable is set
// - watchdog enable set after any reset; clearing it stops watchdog and its reset
// - any write to reset cause address clears watchdog, cause bits unchanged
// - watchdog counts 1 khz ticks; 32 ticks short, 256 ticks long (default)
// - software clears watchdog periodically; expiry resets the system
// - options register written once at init; first write clears the watchdog
// - watchdog holds its count in background debug mode
// - stop entry zeroes the watchdog; counting resumes from zero after stop
// - no vectors; module requests only wake the core from wait or stop
// - each wakeup source gated by its enable; flag still sets when disabled
// - two read-only pending registers, one bit per module; writes ignored
// - pending bit clears once all flags of that module are clear
// - low-voltage detect runs only when enabled; off in stop unless stop enable
// - power-on reset held until supply good; sets power-on and low-voltage causes
// - low-voltage reset when enabled; held until supply recovers; sets cause bit
// - low voltage with irq enable and no reset enable sets flag and requests irq
// - cause bits: 7 power-on, 6 pin, 5 watchdog, 4 opcode, 3 address, 1 low voltage
// - cause bits record sources active at reset; debug reset clears all
// - options register takes only first write, except two serial routing bits
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module srw_top
  import srw_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        i_power_on,
  input  wire logic        i_supply_good,
  input  wire logic        i_low_voltage,
  input  wire logic        i_reset_pin_n,
  input  wire logic        i_bad_opcode,
  input  wire logic        i_bad_address,
  input  wire logic        i_debug_reset_cmd,
  input  wire logic        i_debug_mode,
  input  wire logic        i_wait_mode,
  input  wire logic        i_stop_mode,
  input  wire logic        i_tick_1khz,
  input  wire logic [8:0]  i_mod_flags,
  input  wire logic [8:0]  i_mod_irq_en,
  output logic             o_sys_reset,
  output logic             o_periph_disable,
  output logic             o_pins_hiz,
  output logic [13:0]      o_fetch_addr,
  output logic             o_wakeup,
  output logic             o_low_voltage_irq,
  output logic             o_low_voltage_detect_en,
  output logic             o_stop_enable,
  output logic             o_debug_pin_enable,
  output logic [1:0]       o_serial_route
);
  srw_wdg_if wdg_if ();

  // reset sequencing state
  srw_state_type state_q;
  srw_state_type state_d;
  logic [7:0]    cause_q;
  logic [7:0]    cause_d;
  logic [7:0]    hold_cnt_q;
  logic [7:0]    hold_cnt_d;
  logic [13:0]   fetch_q;
  logic [13:0]   fetch_d;
  // configuration state
  logic [7:0]    options_q;
  logic [7:0]    options_d;
  logic          opt_locked_q;
  logic          opt_locked_d;
  logic [7:0]    pmc_q;
  logic [7:0]    pmc_d;
  logic          lv_flag_q;
  logic          lv_flag_d;
  // tick synchroniser
  logic          tick_s1_q;
  logic          tick_s2_q;
  logic          tick_s3_q;
  // bus state
  logic          aw_full_q;
  logic          aw_full_d;
  logic [7:0]    aw_addr_q;
  logic [7:0]    aw_addr_d;
  logic          w_full_q;
  logic          w_full_d;
  logic [7:0]    w_data_q;
  logic [7:0]    w_data_d;
  logic          w_lane_q;
  logic          w_lane_d;
  logic          bvalid_q;
  logic          bvalid_d;
  logic [1:0]    bresp_q;
  logic [1:0]    bresp_d;
  logic          rvalid_q;
  logic          rvalid_d;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;
  logic [1:0]    rresp_q;
  logic [1:0]    rresp_d;

  logic          do_write;
  logic          wr_cause;
  logic          wr_options;
  logic          wr_pmc;
  logic          lv_active;
  logic          lv_trip;
  logic [7:0]    src_now;
  logic          src_any;
  logic [7:0]    pend1;
  logic [7:0]    pend2;
  logic [8:0]    pending_all;
  logic          in_hold;

  assign in_hold = (state_q == SRW_HOLD);

  // low-voltage detection and pending bits
  always_comb begin
    lv_active = pmc_q[PM_LV_EN] && (!i_stop_mode || pmc_q[PM_LV_SE]);
    lv_trip   = lv_active && i_low_voltage;
    pend1     = i_mod_flags[7:0] & i_mod_irq_en[7:0];
    pend2     = {6'h00, i_mod_flags[8] & i_mod_irq_en[8],
                 lv_flag_q & pmc_q[PM_LV_IE]};
    pending_all = {pend2[1:0], pend1[6:0]} | {8'h00, pend1[7]};
  end

  // reset sources; pin reset only when enabled
  always_comb begin
    src_now          = '0;
    src_now[CS_POR]  = i_power_on;
    src_now[CS_PIN]  = !i_reset_pin_n && options_q[OP_PIN_RST];
    src_now[CS_WDG]  = wdg_if.expire;
    src_now[CS_OPC]  = i_bad_opcode;
    src_now[CS_ADR]  = i_bad_address;
    src_now[CS_LV]   = i_power_on || (lv_trip && pmc_q[PM_LV_RE]);
    src_any          = |src_now || i_debug_reset_cmd;
  end

  // reset sequencer
  always_comb begin
    state_d    = state_q;
    cause_d    = cause_q;
    hold_cnt_d = hold_cnt_q;
    fetch_d    = fetch_q;
    case (state_q)
      SRW_HOLD: begin
        if (i_debug_reset_cmd) begin
          cause_d = '0;
        end else begin
          cause_d = cause_q | src_now;
        end
        if (src_any) begin
          hold_cnt_d = '0;
        end else if (hold_cnt_q != 8'(RST_HOLD_CYC)) begin
          hold_cnt_d = hold_cnt_q + 8'h01;
        end
        // low-voltage causes wait for a good supply before release
        if (!src_any && hold_cnt_q == 8'(RST_HOLD_CYC)
            && (i_supply_good || !cause_q[CS_LV])) begin
          state_d = SRW_RUN;
          fetch_d = RESET_PC;
        end
      end
      SRW_RUN: begin
        if (src_any) begin
          state_d    = SRW_HOLD;
          hold_cnt_d = '0;
          if (i_debug_reset_cmd) begin
            cause_d = '0;
          end else if (src_now[CS_POR]) begin
            cause_d = src_now;
          end else begin
            // a plain low-voltage reset leaves the power-on bit as it was
            cause_d = src_now | (src_now[CS_LV] ? (cause_q & 8'h80) : 8'h00);
          end
        end
      end
      default: begin
        state_d = SRW_HOLD;
      end
    endcase
  end

  // configuration registers
  always_comb begin
    options_d    = options_q;
    opt_locked_d = opt_locked_q;
    pmc_d        = pmc_q;
    lv_flag_d    = lv_flag_q;
    if (in_hold) begin
      // pin reset enable survives all but power-on
      options_d    = OPTIONS_RST;
      options_d[OP_PIN_RST] = options_q[OP_PIN_RST] && !i_power_on;
      opt_locked_d = 1'b0;
      pmc_d        = PMC_RST;
      lv_flag_d    = 1'b0;
    end else begin
      if (wr_options) begin
        if (!opt_locked_q) begin
          options_d    = w_data_q;
          opt_locked_d = 1'b1;
        end else begin
          options_d = (options_q & ~OPTIONS_FREE) | (w_data_q & OPTIONS_FREE);
        end
      end
      if (wr_pmc) begin
        pmc_d = (pmc_q & ~PMC_RW) | (w_data_q & PMC_RW);
        if (w_data_q[PM_LV_ACK]) begin
          lv_flag_d = 1'b0;
        end
      end
      // a new detection beats an acknowledge in the same cycle
      if (lv_trip && !pmc_q[PM_LV_RE]) begin
        lv_flag_d = 1'b1;
      end
    end
  end

  // watchdog hookup
  always_comb begin
    wdg_if.tick     = tick_s2_q && !tick_s3_q;
    wdg_if.clear    = in_hold || wr_cause || (wr_options && !opt_locked_q);
    wdg_if.hold     = i_debug_mode;
    wdg_if.stop     = i_stop_mode;
    wdg_if.enable   = options_q[OP_WDG_EN];
    wdg_if.long_sel = options_q[OP_WDG_LONG];
  end

  srw_watchdog u_watchdog (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .wdg        (wdg_if.wdg)
  );

  // axi4-lite write side: address and data taken in either order
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    s_axi_awready = !aw_full_q && !bvalid_q;
    s_axi_wready  = !w_full_q && !bvalid_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_lane_d = s_axi_wstrb[0];
    end
    do_write = aw_full_q && w_full_q && !bvalid_q;
    wr_cause   = do_write && aw_addr_q == OFS_CAUSE;
    wr_options = do_write && aw_addr_q == OFS_OPTIONS && w_lane_q;
    wr_pmc     = do_write && aw_addr_q == OFS_PMC && w_lane_q;
    if (do_write) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      // pending registers accept writes silently and keep their value
      case (aw_addr_q)
        OFS_CAUSE, OFS_OPTIONS, OFS_PMC, OFS_PEND1, OFS_PEND2: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  // axi4-lite read side
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    s_axi_arready = !rvalid_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (s_axi_araddr)
        OFS_CAUSE:   rdata_d = {24'h0, cause_q};
        OFS_OPTIONS: rdata_d = {24'h0, options_q};
        OFS_PMC:     rdata_d = {24'h0, lv_flag_q, 1'b0, pmc_q[5:0]};
        OFS_PEND1:   rdata_d = {24'h0, pend1};
        OFS_PEND2:   rdata_d = {24'h0, pend2};
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  // registers; power-up begins in hold with power-on causes
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q      <= SRW_HOLD;
      cause_q      <= 8'h82;
      hold_cnt_q   <= '0;
      fetch_q      <= '0;
      options_q    <= OPTIONS_RST;
      opt_locked_q <= 1'b0;
      pmc_q        <= PMC_RST;
      lv_flag_q    <= 1'b0;
      tick_s1_q    <= 1'b0;
      tick_s2_q    <= 1'b0;
      tick_s3_q    <= 1'b0;
      aw_full_q    <= 1'b0;
      aw_addr_q    <= '0;
      w_full_q     <= 1'b0;
      w_data_q     <= '0;
      w_lane_q     <= 1'b0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      rvalid_q     <= 1'b0;
      rdata_q      <= '0;
      rresp_q      <= RESP_OKAY;
    end else begin
      state_q      <= state_d;
      cause_q      <= cause_d;
      hold_cnt_q   <= hold_cnt_d;
      fetch_q      <= fetch_d;
      options_q    <= options_d;
      opt_locked_q <= opt_locked_d;
      pmc_q        <= pmc_d;
      lv_flag_q    <= lv_flag_d;
      tick_s1_q    <= i_tick_1khz;
      tick_s2_q    <= tick_s1_q;
      tick_s3_q    <= tick_s2_q;
      aw_full_q    <= aw_full_d;
      aw_addr_q    <= aw_addr_d;
      w_full_q     <= w_full_d;
      w_data_q     <= w_data_d;
      w_lane_q     <= w_lane_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      rvalid_q     <= rvalid_d;
      rdata_q      <= rdata_d;
      rresp_q      <= rresp_d;
    end
  end

  always_comb begin
    s_axi_bvalid = bvalid_q;
    s_axi_bresp  = bresp_q;
    s_axi_rvalid = rvalid_q;
    s_axi_rdata  = rdata_q;
    s_axi_rresp  = rresp_q;
    o_sys_reset      = in_hold;
    o_periph_disable = in_hold;
    o_pins_hiz       = in_hold;
    o_fetch_addr     = fetch_q;
    // no vectors: pending requests only wake from the low-power modes
    o_wakeup = (i_wait_mode || i_stop_mode) && (|pending_all);
    o_low_voltage_irq       = lv_flag_q && pmc_q[PM_LV_IE];
    o_low_voltage_detect_en = lv_active;
    o_stop_enable           = options_q[OP_STOP_EN];
    o_debug_pin_enable      = options_q[OP_DBG_PIN];
    o_serial_route          = {options_q[OP_SER_CLK], options_q[OP_SER_PIN]};
  end
endmodule : srw_top
`default_nettype wire

/* File: dv/srw_asserts.sv */
// port assertions for the reset, watchdog and wakeup block
`default_nettype none
module srw_asserts (
  input wire logic        i_core_clk,
  input wire logic        i_arst_n,
  input wire logic        i_power_on,
  input wire logic        i_supply_good,
  input wire logic        i_bad_opcode,
  input wire logic        i_bad_address,
  input wire logic        i_debug_reset_cmd,
  input wire logic        i_wait_mode,
  input wire logic        i_stop_mode,
  input wire logic [8:0]  i_mod_flags,
  input wire logic [8:0]  i_mod_irq_en,
  input wire logic        o_sys_reset,
  input wire logic        o_periph_disable,
  input wire logic        o_pins_hiz,
  input wire logic [13:0] o_fetch_addr,
  input wire logic        o_wakeup,
  input wire logic        o_low_voltage_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic por_pend_q;
  logic por_pend_d;
  // a power-on stays pending until the hold is left
  always_comb begin
    por_pend_d = por_pend_q;
    if (i_power_on) begin
      por_pend_d = 1'b1;
    end else if (!o_sys_reset) begin
      por_pend_d = 1'b0;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      por_pend_q <= 1'b1;
    end else begin
      por_pend_q <= por_pend_d;
    end
  end
  sequence s_hold8;
    o_sys_reset [*8];
  endsequence
  sequence s_wake_req;
    !o_sys_reset && (i_wait_mode || i_stop_mode) && |(i_mod_flags & i_mod_irq_en);
  endsequence
  a_hold_min_len: assert property ($rose(o_sys_reset) |-> s_hold8)
    else $error("reset hold too short");
  a_reset_outs_tie: assert property ({o_periph_disable, o_pins_hiz} == {2{o_sys_reset}})
    else $error("peripheral or pin state not tied to reset");
  a_fetch_addr_run: assert property (!o_sys_reset |-> o_fetch_addr == 14'h3ffd)
    else $error("fetch address wrong after reset");
  a_wake_needs_mode: assert property (o_wakeup |-> i_wait_mode || i_stop_mode)
    else $error("wakeup outside wait or stop");
  a_wake_on_enabled: assert property (s_wake_req [*3] |-> o_wakeup)
    else $error("enabled source did not wake");
  a_debug_cmd_reset: assert property (i_debug_reset_cmd |-> ##[1:2] o_sys_reset)
    else $error("debug command gave no reset");
  a_fault_src_reset: assert property ((i_bad_opcode || i_bad_address)
    |-> ##[1:2] o_sys_reset)
    else $error("fault source gave no reset");
  a_por_until_good: assert property ($fell(o_sys_reset) && $past(por_pend_q)
    |-> $past(i_supply_good))
    else $error("power-on hold left before supply good");
  a_lv_irq_cleared: assert property (o_sys_reset [*2] |-> !o_low_voltage_irq)
    else $error("low-voltage request during reset hold");
endmodule // srw_asserts
bind srw_top srw_asserts i_srw_asserts (.*);
`default_nettype wire

/* File: dv/srw_partner.sv */
// far side model: tick source, supply monitor, module flags, boot image
`default_nettype none
module srw_partner #(
  parameter int TICK_HALF = 4,
  parameter int RECOVER   = 12
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sag,
  input  wire logic [8:0]  i_event,
  input  wire logic [8:0]  i_flag_clr,
  input  wire logic [13:0] i_fetch_addr,
  output logic             o_tick,
  output logic             o_supply_good,
  output logic             o_low_voltage,
  output logic [8:0]       o_flags,
  output logic [7:0]       o_fetch_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  int tick_cnt = 0;
  int rec_cnt = 0;
  initial o_tick = 1'b0;
  initial o_flags = 9'h000;
  // tick far faster than 1 khz so long timeouts stay short
  always @(posedge i_core_clk) begin
    tick_cnt <= (tick_cnt == TICK_HALF - 1) ? 0 : tick_cnt + 1;
    if (tick_cnt == TICK_HALF - 1) o_tick <= ~o_tick;
    o_flags <= (o_flags | i_event) & ~i_flag_clr; // flags stay until cleared
    rec_cnt <= i_sag ? RECOVER : (rec_cnt > 0 ? rec_cnt - 1 : 0);
  end
  // supply reads good only some time after a sag ends
  assign o_low_voltage = i_sag;
  assign o_supply_good = !i_sag && rec_cnt == 0;
  assign o_fetch_byte = (i_fetch_addr == 14'h3ffd) ? 8'hbc : 8'h00; // jump at boot fetch
endmodule // srw_partner
`default_nettype wire

/* File: dv/tb_system_reset_watchdog_wakeup.sv */
// self-checking bench for the reset, watchdog and wakeup block
`default_nettype none
module tb_system_reset_watchdog_wakeup;
  timeunit 1ns;
  timeprecision 1ps;
  import srw_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, boot_op;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, o_serial_route, rr;
  logic i_power_on, i_supply_good, i_low_voltage, i_reset_pin_n, i_bad_opcode, i_bad_address;
  logic i_debug_reset_cmd, i_debug_mode, i_wait_mode, i_stop_mode, i_tick_1khz, sag;
  logic [8:0] i_mod_flags, i_mod_irq_en, ev, clr;
  logic o_sys_reset, o_periph_disable, o_pins_hiz, o_wakeup, o_low_voltage_irq;
  logic o_low_voltage_detect_en, o_stop_enable, o_debug_pin_enable;
  logic [13:0] o_fetch_addr;
  int bad_count = 0, checks = 0;
  always #2.5 i_core_clk = ~i_core_clk;
  srw_top i_srw_top (.*);
  srw_partner #(.TICK_HALF(4)) i_srw_partner (.i_core_clk(i_core_clk), .i_sag(sag),
    .i_event(ev), .i_flag_clr(clr), .i_fetch_addr(o_fetch_addr), .o_tick(i_tick_1khz),
    .o_supply_good(i_supply_good), .o_low_voltage(i_low_voltage), .o_flags(i_mod_flags),
    .o_fetch_byte(boot_op));
  task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge i_core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge i_core_clk);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [7:0] e);
    axr(a);
    chk(s, rd, {24'h0, e});
  endtask
  // waits for the hold to end; a hang here counts as a miss
  task automatic wait_rel(input int lim);
    int n = 0;
    while (o_sys_reset !== 1'b0 && n < lim) begin
      @(posedge i_core_clk);
      n++;
    end
    chk("release", 32'(n < lim), 32'h1);
  endtask
  task automatic t_por();
    i_arst_n <= 1'b0;
    cyc(16);
    i_arst_n <= 1'b1;
    cyc(5);
    i_power_on <= 1'b0;
    cyc(40);
    chk("por hold", 32'(o_sys_reset), 32'h1);
    sag <= 1'b0;
    wait_rel(200);
    chk("fetch", 32'(o_fetch_addr), 32'h3ffd);
    chk("boot op", 32'(boot_op), 32'hbc);
    rdc("cause", OFS_CAUSE, 8'h82);
    rdc("options", OFS_OPTIONS, 8'hc2);
    rdc("pmc", OFS_PMC, PMC_RST);
    rdc("pend1", OFS_PEND1, 8'h00);
    axr(8'h40);
    chk("unmapped", 32'(rr), 32'(RESP_SLVERR));
    $display("test por done");
  endtask
  task automatic t_options();
    axw(OFS_OPTIONS, 8'h80);
    rdc("opt first", OFS_OPTIONS, 8'h80);
    axw(OFS_OPTIONS, 8'h7f);
    rdc("opt locked", OFS_OPTIONS, 8'h8c);
    chk("route", 32'(o_serial_route), 32'h3);
    chk("opt pins", 32'({o_stop_enable, o_debug_pin_enable}), 32'h0);
    i_reset_pin_n <= 1'b0;
    cyc(30);
    chk("pin off", 32'(o_sys_reset), 32'h0);
    i_reset_pin_n <= 1'b1;
    $display("test options done");
  endtask
  task automatic t_watchdog();
    int n = 0;
    repeat (3) begin
      axw(OFS_CAUSE, 8'hff);
      cyc(150);
    end
    chk("serviced", 32'(o_sys_reset), 32'h0);
    rdc("cause kept", OFS_CAUSE, 8'h82);
    i_debug_mode <= 1'b1;
    cyc(400);
    chk("debug freeze", 32'(o_sys_reset), 32'h0);
    i_debug_mode <= 1'b0;
    i_stop_mode <= 1'b1;
    cyc(400);
    chk("stop zero", 32'(o_sys_reset), 32'h0);
    i_stop_mode <= 1'b0;
    while (o_sys_reset !== 1'b1 && n < 600) begin
      @(posedge i_core_clk);
      n++;
    end
    chk("short span", 32'(n >= 240 && n <= 280), 32'h1);
    wait_rel(100);
    rdc("wdg cause", OFS_CAUSE, 8'h20);
    rdc("opt reinit", OFS_OPTIONS, 8'hc2);
    $display("test watchdog done");
  endtask
  task automatic t_disable();
    axw(OFS_OPTIONS, 8'h01);
    cyc(2200);
    chk("wdg off", 32'(o_sys_reset), 32'h0);
    i_reset_pin_n <= 1'b0;
    cyc(10);
    chk("pin on", 32'(o_sys_reset), 32'h1);
    i_reset_pin_n <= 1'b1;
    wait_rel(100);
    rdc("pin cause", OFS_CAUSE, 8'h40);
    rdc("opt pin", OFS_OPTIONS, 8'hc3);
    $display("test disable done");
  endtask
  task automatic t_faults();
    logic [7:0] ex [3] = '{8'h10, 8'h08, 8'h00};
    for (int k = 0; k < 3; k++) begin
      i_bad_opcode <= (k == 0);
      i_bad_address <= (k == 1);
      i_debug_reset_cmd <= (k == 2);
      cyc(1);
      i_bad_opcode <= 1'b0;
      i_bad_address <= 1'b0;
      i_debug_reset_cmd <= 1'b0;
      cyc(3);
      chk("fault hold", 32'(o_sys_reset), 32'h1);
      wait_rel(100);
      rdc("fault cause", OFS_CAUSE, ex[k]);
    end
    $display("test faults done");
  endtask
  task automatic t_wakeup();
    axw(OFS_OPTIONS, 8'h00); // watchdog locked off
    for (int i = 0; i < 9; i++) begin
      i_wait_mode <= (i < 8);
      i_stop_mode <= (i == 8);
      ev <= 9'h001 << i;
      i_mod_irq_en <= 9'h000;
      cyc(1);
      ev <= 9'h000;
      cyc(3);
      chk("gated", 32'(o_wakeup), 32'h0);
      i_mod_irq_en <= 9'h001 << i;
      cyc(3);
      chk("wake", 32'(o_wakeup), 32'h1);
      axw(OFS_PEND1, 8'h00);
      chk("pend wr", 32'(rr), 32'(RESP_OKAY));
      rdc("pend1", OFS_PEND1, (i < 8) ? 8'h01 << i : 8'h00);
      rdc("pend2", OFS_PEND2, (i == 8) ? 8'h02 : 8'h00);
      clr <= 9'h001 << i;
      cyc(1);
      clr <= 9'h000;
      cyc(3);
      rdc("pend1 clr", OFS_PEND1, 8'h00);
      rdc("pend2 clr", OFS_PEND2, 8'h00);
    end
    i_wait_mode <= 1'b0;
    i_stop_mode <= 1'b0;
    $display("test wakeup done");
  endtask
  task automatic t_lowv();
    axw(OFS_PMC, 8'h24);
    sag <= 1'b1;
    cyc(5);
    chk("lv irq", 32'(o_low_voltage_irq), 32'h1);
    rdc("lv flag", OFS_PMC, 8'ha4);
    chk("no lv reset", 32'(o_sys_reset), 32'h0);
    sag <= 1'b0;
    cyc(20);
    axw(OFS_PMC, 8'h64);
    rdc("lv ack", OFS_PMC, 8'h24);
    i_stop_mode <= 1'b1;
    cyc(2);
    chk("lv stop off", 32'(o_low_voltage_detect_en), 32'h0);
    i_stop_mode <= 1'b0;
    axw(OFS_PMC, 8'h2c);
    i_stop_mode <= 1'b1;
    cyc(2);
    chk("lv stop on", 32'(o_low_voltage_detect_en), 32'h1);
    i_stop_mode <= 1'b0;
    axw(OFS_PMC, 8'h14);
    sag <= 1'b1;
    cyc(45);
    chk("lv hold", 32'(o_sys_reset), 32'h1);
    sag <= 1'b0;
    wait_rel(200);
    rdc("lv cause", OFS_CAUSE, 8'h02);
    $display("test low voltage done");
  endtask
  initial begin
    {i_arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    {i_bad_opcode, i_bad_address, i_debug_reset_cmd, i_debug_mode} = '0;
    {i_wait_mode, i_stop_mode, i_mod_irq_en, ev, clr} = '0;
    i_power_on = 1'b1;
    i_reset_pin_n = 1'b1;
    sag = 1'b1;
    t_por();
    t_options();
    t_watchdog();
    t_disable();
    t_faults();
    t_wakeup();
    t_lowv();
    test_done();
  end
  initial begin
    #200us;
    bad_count++;
    $display("mismatch run time expected finish seen timeout");
    test_done();
  end
endmodule // tb_system_reset_watchdog_wakeup
`default_nettype wire
